/* File: rwc_core_model.sv */
// behavioural model of the core that issues flag-set strobes and halt requests
`default_nettype none

module rwc_core_model (
   // clock
   input wire logic core_clk,
   // commands from the bench
   input wire logic kickCmd,
   input wire logic [7:0] opCmd,
   input wire logic sleepCmd,
   // towards the block
   output var logic flag_set_instruction = 1'b0,
   output var logic [7:0] flagOperand = 8'h00,
   output var logic haltOrStop = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // instruction issue
   // the operand only means something with the strobe, so it wanders otherwise
   always @(posedge core_clk) begin
      flag_set_instruction <= kickCmd;
      flagOperand <= kickCmd ? opCmd : ~flagOperand;
      haltOrStop <= sleepCmd;
   end
endmodule

`default_nettype wire

/* File: rwc_pkg.sv */
// package of constants and types for the reset and watchdog control block
`default_nettype none

package rwc_pkg;

   // ==========================================================
   // pre-divider
   localparam int unsigned PREDIV_WIDTH = 15;
   localparam int unsigned TAP_TEN_BIT = 9;
   localparam int unsigned TAP_FIFTEEN_BIT = 14;
   localparam logic [14:0] PREDIV_RESET = 15'h0000;

   // ==========================================================
   // initial reset cycle
   localparam int unsigned RESET_CYCLE_TICKS = 16384;
   localparam int unsigned RST_CNT_WIDTH = 15;
   localparam logic [14:0] RST_CNT_RESET = 15'h0000;

   typedef enum logic {
      RWC_LEN_FIXED_COUNT,
      RWC_LEN_HALF_TAP15
   } rwc_len_sel_t;

   typedef enum logic [1:0] {
      RWC_IDLE,
      RWC_HOLD,
      RWC_CYCLE
   } rwc_state_t;

   // ==========================================================
   // core and watchdog
   localparam int unsigned PC_WIDTH = 12;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam int unsigned WDT_WIDTH = 9;
   localparam logic [8:0] WDT_RESET = 9'h000;
   localparam int unsigned WDT_OVF_8 = 8;
   localparam int unsigned WDT_OVF_64 = 64;
   localparam int unsigned WDT_OVF_512 = 512;
   localparam logic [7:0] SF_WDT_OPERAND = 8'h10;

   // ==========================================================
   // state that the rest of the chip takes while reset is active
   typedef struct packed {
      logic coreReset;
      logic [11:0] pcValue;
      logic clearCoreFlags;
      logic portsInput;
      logic pullDownThirdFourth;
      logic debounceTapTen;
      logic toneBaseQuarterOff;
      logic converterOff;
      logic timersOff;
      logic segForce;
      logic segLevel;
      logic slowClockSel;
   } rwc_init_t;

   localparam rwc_init_t INIT_IDLE = '{
      coreReset: 1'b0, pcValue: 12'h000, clearCoreFlags: 1'b0, portsInput: 1'b0,
      pullDownThirdFourth: 1'b0, debounceTapTen: 1'b0, toneBaseQuarterOff: 1'b0,
      converterOff: 1'b0, timersOff: 1'b0, segForce: 1'b0, segLevel: 1'b0,
      slowClockSel: 1'b0};

endpackage

`default_nettype wire

/* File: rwc_reset_ctrl.sv */
// reset sequencer with pre-divider and watchdog for the 4-bit core
`default_nettype none

module rwc_reset_ctrl #(
   parameter rwc_pkg::rwc_len_sel_t LEN_SEL = rwc_pkg::RWC_LEN_FIXED_COUNT,
   parameter int unsigned RESET_TICKS = rwc_pkg::RESET_CYCLE_TICKS,
   parameter int unsigned WDT_OVF_PERIODS = rwc_pkg::WDT_OVF_512,
   parameter bit SEG_ALL_ON = 1'b1,
   parameter bit DUAL_CLOCK = 1'b1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // reset sources from pins and the power-on detector
   input wire logic powerOnReq,
   input wire logic resetPin,
   input wire logic ioPortResetReq,
   // time base from the crystal side, one-cycle enable per base clock
   input wire logic prediv_base_clock,
   // core side
   input wire logic flag_set_instruction,
   input wire logic [7:0] flagOperand,
   input wire logic haltOrStop,
   // reset state towards the chip
   output rwc_pkg::rwc_init_t initState_q,
   output logic watchdogResetCause_q,
   // time base taps
   output logic [rwc_pkg::PREDIV_WIDTH-1:0] prediv_q,
   output logic prediv_tap_ten_q,
   // watchdog state
   output logic watchdog_enabled_flag_q,
   output logic [rwc_pkg::WDT_WIDTH-1:0] watchdog_counter_q,
   output logic watchdogOverflow_q
);

   localparam logic [14:0] LAST_TICK = 15'(RESET_TICKS - 1);
   localparam logic [9:0] TAP_TEN_WRAP = 10'h3ff;

   // ==========================================================
   // decode of the watchdog clear command
   function automatic logic isWatchdogKick(input logic strobe, input logic [7:0] operand);
      isWatchdogKick = strobe && (operand == rwc_pkg::SF_WDT_OPERAND);
   endfunction

   // ==========================================================
   // synchronised request levels
   logic [2:0] reqSync;
   logic powerOnLvl;
   logic pinLvl;
   logic ioLvl;
   logic levelReq;
   logic hardReq;

   rwc_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .asyncIn({ioPortResetReq, resetPin, powerOnReq}),
      .syncOut_q(reqSync)
   );

   assign powerOnLvl = reqSync[0];
   assign pinLvl = reqSync[1];
   assign ioLvl = reqSync[2];
   assign hardReq = powerOnLvl || pinLvl;
   assign levelReq = hardReq || ioLvl;

   // ==========================================================
   // sequencer state
   rwc_pkg::rwc_state_t state_q;
   rwc_pkg::rwc_state_t state_d;
   logic [rwc_pkg::RST_CNT_WIDTH-1:0] cycleCnt_q;
   logic hardCycle_q;
   logic tap15Prev_q;
   logic cycleDone;
   logic inReset;
   logic wdtOvf;
   logic wdtStop;
   logic kick;
   logic tapTenTick;

   assign inReset = (state_q != rwc_pkg::RWC_IDLE);
   assign kick = isWatchdogKick(flag_set_instruction, flagOperand) && !inReset;
   assign tapTenTick = prediv_base_clock && (prediv_q[9:0] == TAP_TEN_WRAP);

   // the tap-fifteen option ends on its first edge after the upper stages were cleared
   always_comb begin
      if (LEN_SEL == rwc_pkg::RWC_LEN_HALF_TAP15) begin
         cycleDone = (prediv_q[rwc_pkg::TAP_FIFTEEN_BIT] != tap15Prev_q);
      end else begin
         cycleDone = prediv_base_clock && (cycleCnt_q == LAST_TICK);
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         rwc_pkg::RWC_IDLE: begin
            if (levelReq) begin
               state_d = rwc_pkg::RWC_HOLD;
            end else if (wdtOvf) begin
               state_d = rwc_pkg::RWC_CYCLE;
            end
         end
         rwc_pkg::RWC_HOLD: begin
            if (!levelReq) begin
               state_d = rwc_pkg::RWC_CYCLE;
            end
         end
         rwc_pkg::RWC_CYCLE: begin
            if (levelReq) begin
               state_d = rwc_pkg::RWC_HOLD;
            end else if (cycleDone && !wdtOvf) begin
               state_d = rwc_pkg::RWC_IDLE;
            end
         end
         default: begin
            state_d = rwc_pkg::RWC_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_q <= rwc_pkg::RWC_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // length count, restarted by any fresh request
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cycleCnt_q <= rwc_pkg::RST_CNT_RESET;
      end else if (state_q != rwc_pkg::RWC_CYCLE || wdtOvf) begin
         cycleCnt_q <= rwc_pkg::RST_CNT_RESET;
      end else if (prediv_base_clock && cycleCnt_q != LAST_TICK) begin
         cycleCnt_q <= cycleCnt_q + 15'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tap15Prev_q <= 1'b0;
      end else if (state_q != rwc_pkg::RWC_CYCLE || wdtOvf) begin
         tap15Prev_q <= 1'b0;
      end else begin
         tap15Prev_q <= prediv_q[rwc_pkg::TAP_FIFTEEN_BIT];
      end
   end

   // power-on or pin cause; the watchdog must stay stopped for the whole cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hardCycle_q <= 1'b1;
      end else if (hardReq) begin
         hardCycle_q <= 1'b1;
      end else if (state_d == rwc_pkg::RWC_IDLE) begin
         hardCycle_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         watchdogResetCause_q <= 1'b0;
      end else if (levelReq) begin
         watchdogResetCause_q <= 1'b0;
      end else if (wdtOvf) begin
         watchdogResetCause_q <= 1'b1;
      end
   end

   // ==========================================================
   // pre-divider; a watchdog reset clears only the stages above tap ten
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prediv_q <= rwc_pkg::PREDIV_RESET;
      end else if (state_q == rwc_pkg::RWC_HOLD) begin
         prediv_q <= rwc_pkg::PREDIV_RESET;
      end else if (wdtOvf) begin
         // low stages keep stepping so the time base loses no base clock
         prediv_q <= {5'h00, prediv_q[9:0] + {9'h000, prediv_base_clock}};
      end else if (prediv_base_clock) begin
         prediv_q <= prediv_q + 15'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prediv_tap_ten_q <= 1'b0;
      end else begin
         prediv_tap_ten_q <= tapTenTick;
      end
   end

   // ==========================================================
   // watchdog; an overflow does not stop it, only a hard cycle does
   assign wdtStop = hardCycle_q && inReset;
   assign wdtOvf = watchdogOverflow_q;

   rwc_watchdog #(
      .OVF_PERIODS(WDT_OVF_PERIODS)
   ) u_wdt (
      .core_clk(core_clk),
      .nrst(nrst),
      .stopClr(wdtStop),
      .kick(kick),
      .tapTenTick(tapTenTick),
      .pause(haltOrStop),
      .wdtEnabled_q(watchdog_enabled_flag_q),
      .wdtCount_q(watchdog_counter_q),
      .wdtOverflow_q(watchdogOverflow_q)
   );

   // ==========================================================
   // reset state driven to the chip, registered from state_d so it changes in the same cycle as state_q
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         initState_q <= rwc_pkg::INIT_IDLE;
         initState_q.coreReset <= 1'b1;
      end else if (state_d != rwc_pkg::RWC_IDLE) begin
         initState_q.coreReset <= 1'b1;
         initState_q.pcValue <= rwc_pkg::PC_RESET;
         initState_q.clearCoreFlags <= 1'b1;
         initState_q.portsInput <= 1'b1;
         initState_q.pullDownThirdFourth <= 1'b1;
         initState_q.debounceTapTen <= 1'b1;
         initState_q.toneBaseQuarterOff <= 1'b1;
         initState_q.converterOff <= 1'b1;
         initState_q.timersOff <= 1'b1;
         initState_q.segForce <= 1'b1;
         initState_q.segLevel <= SEG_ALL_ON;
         initState_q.slowClockSel <= DUAL_CLOCK;
      end else begin
         initState_q <= rwc_pkg::INIT_IDLE;
      end
   end

endmodule

`default_nettype wire

/* File: rwc_reset_ctrl_assertions.sv */
// concurrent checks on the ports of the reset and watchdog control block
`default_nettype none

module rwc_reset_ctrl_chk #(
   parameter int unsigned RESET_TICKS = 16,
   parameter int unsigned WDT_OVF_PERIODS = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // requests and core side
   input wire logic powerOnReq,
   input wire logic resetPin,
   input wire logic ioPortResetReq,
   input wire logic prediv_base_clock,
   input wire logic flag_set_instruction,
   input wire logic [7:0] flagOperand,
   input wire logic haltOrStop,
   // outputs of the block
   input wire rwc_pkg::rwc_init_t initState_q,
   input wire logic watchdogResetCause_q,
   input wire logic [14:0] prediv_q,
   input wire logic prediv_tap_ten_q,
   input wire logic watchdog_enabled_flag_q,
   input wire logic [8:0] watchdog_counter_q,
   input wire logic watchdogOverflow_q
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0] LAST = 9'(WDT_OVF_PERIODS - 1);
   localparam logic [22:0] RST_VAL = {1'b1, 12'h000, 10'h3ff};
   logic [15:0] runLen_q;
   logic stepNow;
   logic kickOk;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // helpers
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         runLen_q <= 16'h0000;
      end else begin
         runLen_q <= initState_q.coreReset ? runLen_q + 16'h0001 : 16'h0000;
      end
   end
   // tick seen on the divider itself, so either tick pipelining passes
   assign stepNow = watchdog_enabled_flag_q && !haltOrStop && !flag_set_instruction &&
      !initState_q.coreReset && prediv_base_clock && prediv_q[9:0] == 10'h3ff;
   assign kickOk = flag_set_instruction && flagOperand == rwc_pkg::SF_WDT_OPERAND &&
      !initState_q.coreReset;

   // ==========================================================
   // checks
   state_fields_a: assert property ($past(nrst, 2) |-> initState_q ==
      (initState_q.coreReset ? RST_VAL : rwc_pkg::INIT_IDLE)) else $error("reset state wrong");
   cycle_len_a: assert property ($fell(initState_q.coreReset) |->
      runLen_q >= RESET_TICKS - 1) else $error("reset cycle too short");
   req_hold_a: assert property ((resetPin || powerOnReq || ioPortResetReq) [*6] |->
      initState_q.coreReset) else $error("request not holding reset");
   pin_stops_a: assert property ((resetPin || powerOnReq) [*8] |->
      !watchdog_enabled_flag_q) else $error("watchdog flag survived");
   kick_clear_a: assert property (kickOk && !$past(initState_q.coreReset) |=>
      watchdog_enabled_flag_q && watchdog_counter_q == 9'h000) else $error("kick lost");
   wdt_step_a: assert property (stepNow && watchdog_counter_q != LAST |-> ##[1:2]
      watchdog_counter_q == $past(watchdog_counter_q) + 9'h001) else $error("no step");
   wdt_ovf_a: assert property (stepNow && watchdog_counter_q == LAST |-> ##[1:2]
      watchdogOverflow_q && watchdog_counter_q == 9'h000) else $error("no overflow");
   ovf_reset_a: assert property (watchdogOverflow_q |-> ##2 initState_q.coreReset)
      else $error("overflow without reset");
   flag_kept_a: assert property (watchdogOverflow_q |-> watchdog_enabled_flag_q [*8])
      else $error("flag lost on watchdog reset");
   prediv_kept_a: assert property ($past(watchdogOverflow_q) |-> prediv_q[9:0] ==
      $past(prediv_q[9:0]) + {9'h000, $past(prediv_base_clock)}) else $error("divider reset");
   halt_hold_a: assert property (watchdog_enabled_flag_q && haltOrStop &&
      !flag_set_instruction && !initState_q.coreReset |=> $stable(watchdog_counter_q))
      else $error("count moved in halt");
   tap_ten_a: assert property (prediv_tap_ten_q |-> prediv_q[9:0] == 10'h000 &&
      $past(prediv_base_clock)) else $error("tap ten misplaced");
endmodule

bind rwc_reset_ctrl rwc_reset_ctrl_chk #(
   .RESET_TICKS(RESET_TICKS),
   .WDT_OVF_PERIODS(WDT_OVF_PERIODS)
) chk_u (.core_clk, .nrst, .powerOnReq, .resetPin, .ioPortResetReq, .prediv_base_clock,
   .flag_set_instruction, .flagOperand, .haltOrStop, .initState_q, .watchdogResetCause_q,
   .prediv_q, .prediv_tap_ten_q, .watchdog_enabled_flag_q, .watchdog_counter_q,
   .watchdogOverflow_q);

`default_nettype wire

/* File: rwc_reset_ctrl_bench.sv */
// self-checking bench for the reset and watchdog control block
`default_nettype none

module rwc_reset_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned RT = 16;
   logic core_clk = 1'b0, nrst = 1'b0, powerOnReq = 1'b0, resetPin = 1'b0;
   logic ioPortResetReq = 1'b0, prediv_base_clock = 1'b1;
   logic kickCmd = 1'b0, sleepCmd = 1'b0;
   logic [7:0] opCmd = 8'h00;
   logic flag_set_instruction, haltOrStop, prediv_tap_ten_q, watchdogResetCause_q;
   logic watchdog_enabled_flag_q, watchdogOverflow_q;
   logic [7:0] flagOperand;
   logic [14:0] prediv_q;
   logic [8:0] watchdog_counter_q;
   rwc_pkg::rwc_init_t initState_q;
   int n_mismatch = 0, n_checks = 0, cyc = 0, k, n, s;

   rwc_core_model core_u (.core_clk, .kickCmd, .opCmd, .sleepCmd, .flag_set_instruction,
      .flagOperand, .haltOrStop);
   rwc_reset_ctrl #(.RESET_TICKS(RT), .WDT_OVF_PERIODS(8)) dut_u (.core_clk, .nrst,
      .powerOnReq, .resetPin, .ioPortResetReq, .prediv_base_clock, .flag_set_instruction,
      .flagOperand, .haltOrStop, .initState_q, .watchdogResetCause_q, .prediv_q,
      .prediv_tap_ten_q, .watchdog_enabled_flag_q, .watchdog_counter_q, .watchdogOverflow_q);

   // ==========================================================
   // helpers
   task final_report;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // outputs are sampled on the falling edge, well clear of updates
   task tick(input int c);
      repeat (c) @(negedge core_clk);
   endtask
   task kick(input logic [7:0] op);
      @(posedge core_clk) kickCmd <= 1'b1;
      opCmd <= op;
      @(posedge core_clk) kickCmd <= 1'b0;
      tick(2);
   endtask
   // lands half a tap-ten period after a tick, far from the next one
   task align;
      for (k = 0; k < 1100 && prediv_tap_ten_q !== 1'b1; k++) tick(1);
      tick(512);
   endtask
   task req(input int src, input int c);
      @(posedge core_clk);
      case (src)
         0: powerOnReq <= 1'b1;
         1: resetPin <= 1'b1;
         default: ioPortResetReq <= 1'b1;
      endcase
      tick(c);
      @(posedge core_clk) powerOnReq <= 1'b0;
      resetPin <= 1'b0;
      ioPortResetReq <= 1'b0;
   endtask
   task waitLevel(input logic v);
      for (k = 0; k < 300 && initState_q.coreReset !== v; k++) tick(1);
      n = k;
   endtask

   initial forever #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   // ==========================================================
   // sequence
   initial begin
      tick(8);
      @(posedge core_clk) nrst <= 1'b1;
      tick(2);
      chk(initState_q, {1'b1, 12'h000, 10'h3ff});
      waitLevel(1'b0);
      chk(n >= RT, 1);
      chk(initState_q, rwc_pkg::INIT_IDLE);
      chk(watchdog_enabled_flag_q, 0);
      kick(8'h11);
      chk(watchdog_enabled_flag_q, 0);
      kick(8'h10);
      chk({watchdog_enabled_flag_q, watchdog_counter_q}, 10'h200);
      align;
      chk(watchdog_counter_q, 9'h001);
      kick(8'h10);
      @(posedge core_clk) sleepCmd <= 1'b1;
      tick(2);
      align;
      align;
      chk(watchdog_counter_q, 9'h000);
      @(posedge core_clk) sleepCmd <= 1'b0;
      tick(2);
      align;
      chk(watchdog_counter_q, 9'h001);
      // six more ticks and a half period until the eighth tick overflows
      for (k = 0; k < 9000 && watchdogOverflow_q !== 1'b1; k++) tick(1);
      chk(k > 6600 && k < 6700, 1);
      waitLevel(1'b1);
      chk({watchdogResetCause_q, watchdog_enabled_flag_q}, 2'b11);
      waitLevel(1'b0);
      chk(watchdog_enabled_flag_q, 1);
      for (s = 0; s < 3; s++) begin
         kick(8'h10);
         req(s, 40);
         tick(1);
         chk(initState_q.coreReset, 1);
         chk(watchdog_enabled_flag_q, s == 2);
         waitLevel(1'b0);
         chk(n >= RT, 1);
      end
      chk(watchdogResetCause_q, 0);
      req(2, 6);
      waitLevel(1'b1);
      tick(8);
      req(2, 6);
      waitLevel(1'b0);
      chk(n >= RT, 1);
      final_report();
   end
endmodule

`default_nettype wire

/* File: rwc_sync.sv */
// three-stage input synchroniser that accepts a change once stages two and three agree
`default_nettype none

module rwc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // asynchronous inputs
   input wire logic [WIDTH-1:0] asyncIn,
   // filtered level
   output logic [WIDTH-1:0] syncOut_q
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;

   // ==========================================================
   // stage one feeds stage two only
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               syncOut_q[i] <= 1'b0;
            end else if (stage2_q[i] == stage3_q[i]) begin
               syncOut_q[i] <= stage3_q[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* File: rwc_watchdog.sv */
// nine-bit watchdog counter clocked by the tenth pre-divider tap
`default_nettype none

module rwc_watchdog #(
   parameter int unsigned OVF_PERIODS = rwc_pkg::WDT_OVF_512
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // control
   input wire logic stopClr,
   input wire logic kick,
   input wire logic tapTenTick,
   input wire logic pause,
   // state
   output logic wdtEnabled_q,
   output logic [rwc_pkg::WDT_WIDTH-1:0] wdtCount_q,
   output logic wdtOverflow_q
);

   localparam logic [8:0] LAST_COUNT = 9'(OVF_PERIODS - 1);

   logic atLast;
   logic advance;

   assign advance = wdtEnabled_q && tapTenTick && !pause;
   assign atLast = (wdtCount_q == LAST_COUNT);

   // ==========================================================
   // enabled flag: power-on or pin cycle clears, flag-set command sets
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wdtEnabled_q <= 1'b0;
      end else if (stopClr) begin
         wdtEnabled_q <= 1'b0;
      end else if (kick) begin
         wdtEnabled_q <= 1'b1;
      end
   end

   // ==========================================================
   // counter; a kick in the same cycle as overflow wins, so no reset follows
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wdtCount_q <= rwc_pkg::WDT_RESET;
      end else if (stopClr || kick) begin
         wdtCount_q <= rwc_pkg::WDT_RESET;
      end else if (advance) begin
         wdtCount_q <= atLast ? rwc_pkg::WDT_RESET : wdtCount_q + 9'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wdtOverflow_q <= 1'b0;
      end else begin
         wdtOverflow_q <= advance && atLast && !stopClr && !kick;
      end
   end

endmodule

`default_nettype wire
